// [logic/ffm_pkg.sv]
// Shared constants and carrier types for the feed and fuse fault monitor
package ffm_pkg;
    // Clock rate and timer tick base
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned TICK_US = 1000;
    // Default prescaler terminal count for a 1 ms tick
    localparam logic [15:0] PRESC_DEFAULT = 16'(CLK_MHZ * TICK_US - 1);
    localparam logic [15:0] PRESC_ONE = 16'h0001;
    // Supervision times in milliseconds, as specified
    localparam int unsigned FUSE_START_MS = 1000;
    localparam int unsigned FUSE_HOLD_MS = 2000;
    localparam int unsigned TRAY_LOWER_MS = 1500;
    localparam int unsigned TRAY_RISE_MS = 10000;
    localparam int unsigned TRAY_RERISE_MS = 3000;
    localparam int unsigned LCT_LIFT_MS = 2500;
    localparam int unsigned BYPASS_MS = 6500;
    // Same times in prescaler ticks
    localparam logic [15:0] FUSE_START_TK = 16'(FUSE_START_MS * 1000 / TICK_US);
    localparam logic [15:0] FUSE_HOLD_TK = 16'(FUSE_HOLD_MS * 1000 / TICK_US);
    localparam logic [15:0] TRAY_LOWER_TK = 16'(TRAY_LOWER_MS * 1000 / TICK_US);
    localparam logic [15:0] TRAY_RISE_TK = 16'(TRAY_RISE_MS * 1000 / TICK_US);
    localparam logic [15:0] TRAY_RERISE_TK = 16'(TRAY_RERISE_MS * 1000 / TICK_US);
    localparam logic [15:0] LCT_LIFT_TK = 16'(LCT_LIFT_MS * 1000 / TICK_US);
    localparam logic [15:0] BYPASS_TK = 16'(BYPASS_MS * 1000 / TICK_US);
    // Fault flag positions
    localparam int unsigned NUM_FAULTS = 8;
    localparam int unsigned NUM_TRAYS = 3;
    localparam int unsigned FLT_FUSER = 0;
    localparam int unsigned FLT_TRAY1 = 1;
    localparam int unsigned FLT_TRAY2 = 2;
    localparam int unsigned FLT_TRAY3 = 3;
    localparam int unsigned FLT_TRAY4 = 4;
    localparam int unsigned FLT_LCT = 5;
    localparam int unsigned FLT_BYP_UP = 6;
    localparam int unsigned FLT_BYP_DN = 7;
    // Per-tray sensor and event bundle
    typedef struct packed {
        logic lower_start;
        logic rise_start;
        logic rerise_start;
        logic upper_limit;
        logic pick_solenoid;
    } ffm_tray_type;
    // Latched service code flags, msb first
    typedef struct packed {
        logic bypass_lower_fault_code;
        logic bypass_upper_fault_code;
        logic large_tray_lift_fault_code;
        logic fourth_tray_fault_code;
        logic third_tray_fault_code;
        logic second_tray_fault_code;
        logic first_tray_fault_code;
        logic fuser_drive_fault_code;
    } ffm_fault_type;
endpackage

// [logic/ffm_timer.sv]
// Restartable tick-based timeout timer
`timescale 1ns/1ps
`default_nettype none
module ffm_timer
    import ffm_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Timing control
    input wire logic i_tick,
    input wire logic i_start,
    input wire logic i_run,
    input wire logic [15:0] i_limit,
    // Result
    output logic o_expired
);
    logic active_q; // Timer armed
    logic active_d;
    logic [15:0] cnt_q; // Elapsed ticks
    logic [15:0] cnt_d;

    // Expiry only while the watched condition still holds
    assign o_expired = active_q && i_run && (cnt_q == i_limit);

    // Next state: a recurring start always restarts from zero
    always_comb
    begin
        active_d = active_q;
        cnt_d = cnt_q;
        if (i_start)
        begin
            active_d = 1'b1; // R11
            cnt_d = 16'h0000;
        end
        else if (!i_run || o_expired)
        begin
            active_d = 1'b0; // Condition cleared or fault taken: stop
        end
        else if (i_tick)
        begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    // State registers, frozen while enable is low
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            active_q <= 1'b0;
            cnt_q <= 16'h0000;
        end
        else if (i_ce)
        begin
            active_q <= active_d;
            cnt_q <= cnt_d;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    AST_RESTART: assert property (i_ce && i_start |=> active_q && cnt_q == 16'h0000) // R11
        else $error("timer did not restart on start");
    AST_STOP_ON_EXPIRE: assert property (i_ce && o_expired && !i_start |=> !active_q) // R10
        else $error("timer kept running after expiry");
endmodule // ffm_timer
`default_nettype wire

// [logic/ffm_monitor.sv]
// Feed and fuse fault monitor: timeout supervision of motors and lifts
// Contract
// R01: Fuser feedback bad 1 s after trigger
// R02: Fuser feedback bad 2 s while triggered
// R03: Tray sensor low 1.5 s after lowering
// R04: Tray sensor high 10 s after rising
// R05: Sensor high 3 s re-rise, or solenoid off
// R06: Second tray never faults; trays 3, 4 checked
// R07: Large tray upper limit 2.5 s after end
// R08: Bypass upper limit missing 6.5 s after raise
// R09: Bypass lower limit missing 6.5 s after lower
// R10: Faults latch until clear; timer then stops
// R11: Prescaled tick timers restart on new start
`timescale 1ns/1ps
`default_nettype none
module ffm_monitor
    import ffm_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Timer prescaler: clocks per tick minus one
    input wire logic [15:0] i_presc_div,
    // Fusing motor
    input wire logic i_fuse_trigger,
    input wire logic i_fuse_feedback_ok,
    // Main paper trays 1, 3 and 4
    input wire ffm_tray_type [NUM_TRAYS-1:0] i_tray,
    // Large capacity tray
    input wire logic i_large_capacity_tray_lifting,
    input wire logic i_large_capacity_tray_paper_end,
    input wire logic i_large_capacity_tray_upper_limit,
    // Bypass table
    input wire logic i_bypass_raise_start,
    input wire logic i_bypass_lower_start,
    input wire logic i_bypass_upper_limit,
    input wire logic i_bypass_lower_limit,
    // Fault flags and their clear
    input wire logic [NUM_FAULTS-1:0] i_fault_clr,
    output ffm_fault_type o_fault
);
    logic [15:0] presc_q; // Prescaler count
    logic [15:0] presc_d;
    logic tick; // One-cycle timebase strobe
    logic trig_q; // Previous trigger level
    logic trig_d;
    logic bad_q; // Previous feedback-bad level
    logic bad_d;
    logic pend_q; // Previous paper end level
    logic pend_d;
    logic [NUM_TRAYS-1:0] sol_q; // Previous solenoid levels
    logic [NUM_TRAYS-1:0] sol_d;
    logic [NUM_FAULTS-1:0] fault_q; // Latched fault flags
    logic [NUM_FAULTS-1:0] fault_d;
    logic [NUM_FAULTS-1:0] set_vec; // Fault set strobes
    logic fuse_bad; // Feedback out of range
    logic fuse_exp_start; // Early check expired
    logic fuse_exp_hold; // Continuous check expired
    logic lct_exp; // Large tray check expired
    logic byp_up_exp; // Bypass raise expired
    logic byp_dn_exp; // Bypass lower expired
    logic [NUM_TRAYS-1:0] tray_set; // Per-tray fault strobes
    logic [NUM_TRAYS-1:0] tray_lo_exp; // Lowering check expired
    logic [NUM_TRAYS-1:0] tray_sol_off; // Solenoid release with sensor high
    logic [NUM_TRAYS-1:0] tray_flt; // Current per-tray flag
    localparam int unsigned TRAY_FLT_IDX [NUM_TRAYS] = '{FLT_TRAY1, FLT_TRAY3, FLT_TRAY4};

    assign fuse_bad = !i_fuse_feedback_ok;
    assign o_fault = ffm_fault_type'(fault_q);

    // Prescaler: one tick per programmed count; a zero divider ticks every clock
    assign tick = i_ce && (presc_q >= i_presc_div); // R11
    always_comb
    begin
        presc_d = tick ? 16'h0000 : presc_q + PRESC_ONE;
    end
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            presc_q <= 16'h0000;
        end
        else if (i_ce)
        begin
            presc_q <= presc_d;
        end
    end

    // Edge history of level inputs
    always_comb
    begin
        trig_d = i_fuse_trigger;
        bad_d = fuse_bad;
        pend_d = i_large_capacity_tray_paper_end;
        for (int t = 0; t < NUM_TRAYS; t++)
        begin
            sol_d[t] = i_tray[t].pick_solenoid;
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            trig_q <= 1'b0;
            bad_q <= 1'b0;
            pend_q <= 1'b0;
            sol_q <= '0;
        end
        else if (i_ce)
        begin
            trig_q <= trig_d;
            bad_q <= bad_d;
            pend_q <= pend_d;
            sol_q <= sol_d;
        end
    end

    // Fuser: armed on trigger rise, judged 1 s later if still bad
    ffm_timer u_fuse_start (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_tick(tick),
        .i_start(i_fuse_trigger && !trig_q), // R01
        .i_run(i_fuse_trigger && fuse_bad && !fault_q[FLT_FUSER]),
        .i_limit(FUSE_START_TK),
        .o_expired(fuse_exp_start)
    );

    // Fuser: a new bad span under trigger must not last 2 s
    ffm_timer u_fuse_hold (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_tick(tick),
        .i_start(i_fuse_trigger && fuse_bad && !(trig_q && bad_q)), // R02
        .i_run(i_fuse_trigger && fuse_bad && !fault_q[FLT_FUSER]),
        .i_limit(FUSE_HOLD_TK),
        .o_expired(fuse_exp_hold)
    );

    // Trays 1, 3, 4 share one checker each; tray 2 has none
    for (genvar t = 0; t < NUM_TRAYS; t++)
    begin : g_tray
        logic up_exp; // Rise check expired
        logic rr_exp; // Re-rise check expired
        assign tray_flt[t] = fault_q[TRAY_FLT_IDX[t]];
        // Sensor must go high within 1.5 s of lowering
        ffm_timer u_lower (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_ce(i_ce),
            .i_tick(tick),
            .i_start(i_tray[t].lower_start), // R03
            .i_run(!i_tray[t].upper_limit && !tray_flt[t]),
            .i_limit(TRAY_LOWER_TK),
            .o_expired(tray_lo_exp[t])
        );
        // Sensor must drop within 10 s of rising
        ffm_timer u_rise (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_ce(i_ce),
            .i_tick(tick),
            .i_start(i_tray[t].rise_start), // R04
            .i_run(i_tray[t].upper_limit && !tray_flt[t]),
            .i_limit(TRAY_RISE_TK),
            .o_expired(up_exp)
        );
        // Sensor must drop within 3 s of a renewed rise
        ffm_timer u_rerise (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_ce(i_ce),
            .i_tick(tick),
            .i_start(i_tray[t].rerise_start), // R05
            .i_run(i_tray[t].upper_limit && !tray_flt[t]),
            .i_limit(TRAY_RERISE_TK),
            .o_expired(rr_exp)
        );
        // Solenoid release while the sensor is still high faults at once
        assign tray_sol_off[t] = sol_q[t] && !i_tray[t].pick_solenoid
            && i_tray[t].upper_limit; // R05
        assign tray_set[t] = tray_lo_exp[t] || up_exp || rr_exp || tray_sol_off[t];
    end

    // Large tray: upper limit due 2.5 s after paper end, while lifting
    ffm_timer u_lct (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_tick(tick),
        .i_start(i_large_capacity_tray_lifting && i_large_capacity_tray_paper_end
            && !pend_q), // R07
        .i_run(i_large_capacity_tray_lifting && !i_large_capacity_tray_upper_limit
            && !fault_q[FLT_LCT]),
        .i_limit(LCT_LIFT_TK),
        .o_expired(lct_exp)
    );

    // Bypass table raise supervision
    ffm_timer u_byp_up (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_tick(tick),
        .i_start(i_bypass_raise_start), // R08
        .i_run(!i_bypass_upper_limit && !fault_q[FLT_BYP_UP]),
        .i_limit(BYPASS_TK),
        .o_expired(byp_up_exp)
    );

    // Bypass table lower supervision
    ffm_timer u_byp_dn (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_tick(tick),
        .i_start(i_bypass_lower_start), // R09
        .i_run(!i_bypass_lower_limit && !fault_q[FLT_BYP_DN]),
        .i_limit(BYPASS_TK),
        .o_expired(byp_dn_exp)
    );

    // Fault latch: set beats a simultaneous clear
    always_comb
    begin
        set_vec = '0;
        set_vec[FLT_FUSER] = fuse_exp_start || fuse_exp_hold; // R01
        set_vec[FLT_TRAY1] = tray_set[0];
        set_vec[FLT_TRAY2] = 1'b0; // R06
        set_vec[FLT_TRAY3] = tray_set[1]; // R06
        set_vec[FLT_TRAY4] = tray_set[2];
        set_vec[FLT_LCT] = lct_exp;
        set_vec[FLT_BYP_UP] = byp_up_exp;
        set_vec[FLT_BYP_DN] = byp_dn_exp;
        fault_d = (fault_q & ~i_fault_clr) | set_vec; // R10
    end
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            fault_q <= '0;
        end
        else if (i_ce)
        begin
            fault_q <= fault_d;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    AST_FUSE_CAUSE: assert property (i_ce && $rose(fault_q[FLT_FUSER])
        |-> $past(i_fuse_trigger) && $past(fuse_bad)) // R01
        else $error("fuser fault without trigger and bad feedback");
    AST_FUSE_HOLD: assert property (i_ce && fuse_exp_hold |=> fault_q[FLT_FUSER]) // R02
        else $error("fuser hold expiry not latched");
    AST_TRAY_LOWER: assert property (i_ce && tray_lo_exp[0]
        |-> !i_tray[0].upper_limit ##1 o_fault.first_tray_fault_code) // R03
        else $error("tray lowering fault wrong");
    AST_TRAY_RISE: assert property (i_ce && $rose(o_fault.third_tray_fault_code)
        |-> $past(tray_lo_exp[1]) || $past(i_tray[1].upper_limit)) // R04
        else $error("third tray fault without cause");
    AST_SOL_OFF: assert property (i_ce && sol_q[2] && !i_tray[2].pick_solenoid
        && i_tray[2].upper_limit |=> o_fault.fourth_tray_fault_code) // R05
        else $error("solenoid release with sensor high not flagged");
    AST_NO_TRAY2: assert property (!o_fault.second_tray_fault_code) // R06
        else $error("second tray fault raised");
    AST_LCT: assert property (i_ce && $rose(fault_q[FLT_LCT])
        |-> $past(i_large_capacity_tray_lifting) && $past(!i_large_capacity_tray_upper_limit)) // R07
        else $error("large tray fault without cause");
    AST_BYP_UP: assert property (i_ce && $rose(fault_q[FLT_BYP_UP])
        |-> $past(!i_bypass_upper_limit)) // R08
        else $error("bypass upper fault while limit seen");
    AST_BYP_DN: assert property (i_ce && $rose(fault_q[FLT_BYP_DN])
        |-> $past(!i_bypass_lower_limit)) // R09
        else $error("bypass lower fault while limit seen");
    AST_HOLD: assert property (i_ce && fault_q[FLT_LCT] && !i_fault_clr[FLT_LCT]
        |=> fault_q[FLT_LCT]) // R10
        else $error("fault dropped without clear");
    AST_SET_WINS: assert property (i_ce && set_vec[FLT_BYP_UP] |=> fault_q[FLT_BYP_UP]) // R10
        else $error("fault set lost against clear");
    AST_TICK: assert property (i_ce && tick |=> presc_q == 16'h0000) // R11
        else $error("prescaler did not wrap on tick");

    COV_FUSE: cover property (fuse_exp_start);
    COV_TRAY_SOL: cover property (tray_sol_off[0]);
    COV_BYP: cover property (byp_dn_exp);
endmodule // ffm_monitor
`default_nettype wire

// [sim/ffm_plant.sv]
// Model of the fusing motor and the bypass lift table facing the monitor
`timescale 1ns/1ps
`default_nettype none
module ffm_plant
    import ffm_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Drive commands and injected faults
    input wire logic i_fuse_trigger,
    input wire logic i_fuse_stall,
    input wire logic i_raise,
    input wire logic i_lower,
    // Response times in clocks, zero means the motor is stuck
    input wire logic [15:0] i_fuse_dly,
    input wire logic [15:0] i_move_dly,
    // Sensor levels back to the monitor
    output logic o_fuse_ok,
    output logic o_upper,
    output logic o_lower
);
    logic [15:0] fuse_cnt_q; // Clocks since drive began
    logic [15:0] move_cnt_q; // Clocks since table motion began
    logic going_up_q; // Direction of the last motion
    logic moving_q; // Table between limits
    // Motor reaches speed after its delay, loses it when stalled
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            fuse_cnt_q <= 16'h0000;
            o_fuse_ok <= 1'b0;
        end
        else if (!i_fuse_trigger || i_fuse_stall)
        begin
            // No drive or a jam: feedback out of range at once
            fuse_cnt_q <= 16'h0000;
            o_fuse_ok <= 1'b0;
        end
        else
        begin
            fuse_cnt_q <= fuse_cnt_q + 16'h0001;
            o_fuse_ok <= (i_fuse_dly != 16'h0000) && (fuse_cnt_q >= i_fuse_dly);
        end
    end
    // Table leaves its old limit at once and makes the new one late
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            move_cnt_q <= 16'h0000;
            going_up_q <= 1'b0;
            moving_q <= 1'b0;
            o_upper <= 1'b0;
            o_lower <= 1'b1;
        end
        else if (i_raise || i_lower)
        begin
            move_cnt_q <= 16'h0001;
            going_up_q <= i_raise;
            moving_q <= 1'b1;
            o_upper <= 1'b0;
            o_lower <= 1'b0;
        end
        else if (moving_q && i_move_dly != 16'h0000 && move_cnt_q >= i_move_dly)
        begin
            // Limit reached, motor stops
            moving_q <= 1'b0;
            o_upper <= going_up_q;
            o_lower <= !going_up_q;
        end
        else if (moving_q)
            move_cnt_q <= move_cnt_q + 16'h0001;
    end
endmodule // ffm_plant
`default_nettype wire

// [sim/tb_feed_fuse_fault_monitor.sv]
// Self-checking bench for the feed and fuse fault monitor
`timescale 1ns/1ps
`default_nettype none
module tb_feed_fuse_fault_monitor
    import ffm_pkg::*;
;
    logic i_clk; // 50 MHz clock
    logic i_resetn; // Active low reset
    logic ce; // Clock enable, dropped once in mid-count
    logic [15:0] presc; // Clocks per tick minus one
    logic trig; // Fusing drive on
    logic stall; // Jams the fusing motor
    logic [15:0] fuse_dly; // Motor spin-up time
    logic [15:0] move_dly; // Table travel time
    logic raise; // Table up strobe
    logic lower; // Table down strobe
    logic fuse_ok;
    logic byp_up;
    logic byp_dn;
    logic lct_lift;
    logic lct_end;
    logic lct_up; // Upper limit, made only in the in-time case
    logic [NUM_FAULTS-1:0] clr;
    ffm_tray_type [NUM_TRAYS-1:0] tray;
    ffm_fault_type fault;
    int n_fail;
    int check_count;
    int unsigned tray_bit [NUM_TRAYS] = '{FLT_TRAY1, FLT_TRAY3, FLT_TRAY4}; // Flag per tray
    ffm_monitor dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_presc_div(presc),
        .i_fuse_trigger(trig), .i_fuse_feedback_ok(fuse_ok), .i_tray(tray),
        .i_large_capacity_tray_lifting(lct_lift), .i_large_capacity_tray_paper_end(lct_end),
        .i_large_capacity_tray_upper_limit(lct_up), .i_bypass_raise_start(raise),
        .i_bypass_lower_start(lower), .i_bypass_upper_limit(byp_up),
        .i_bypass_lower_limit(byp_dn), .i_fault_clr(clr), .o_fault(fault));
    ffm_plant plant (.i_clk(i_clk), .i_resetn(i_resetn), .i_fuse_trigger(trig),
        .i_fuse_stall(stall), .i_raise(raise), .i_lower(lower), .i_fuse_dly(fuse_dly),
        .i_move_dly(move_dly), .o_fuse_ok(fuse_ok), .o_upper(byp_up), .o_lower(byp_dn));
    // Free-running clock
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // Clocks of a timeout at the current tick rate
    function automatic int unsigned exp_cycles(input logic [15:0] tk);
        return int'(tk) * (int'(presc) + 1);
    endfunction
    function automatic logic [7:0] one_hot(input int unsigned b);
        return 8'h01 << b;
    endfunction
    // Waits then steps off the edge so outputs have settled
    task automatic tick(input int unsigned n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Strobe codes: 0 up, 1 down, 2 plate lower, 3 rise, 4 re-rise, 5 solenoid
    task automatic drive(input int unsigned w, input int unsigned t, input logic v);
        case (w)
            0: raise <= v;
            1: lower <= v;
            2: tray[t].lower_start <= v;
            3: tray[t].rise_start <= v;
            4: tray[t].rerise_start <= v;
            default: tray[t].pick_solenoid <= v;
        endcase
    endtask
    task automatic strobe(input int unsigned w, input int unsigned t);
        @(posedge i_clk);
        drive(w, t, 1'b1);
        @(posedge i_clk);
        drive(w, t, 1'b0);
        #1;
    endtask
    // Quiet just before the limit, one flag soon after, sticky, then cleared for good
    task automatic expect_fault(input int unsigned cyc, input int unsigned b, input string name);
        int unsigned k;
        k = 0;
        if (cyc > 3)
        begin
            tick(cyc - 3);
            check(fault, 8'h00);
        end
        while (fault[b] !== 1'b1 && k < 3 * (presc + 1) + 9)
        begin
            tick(1);
            k++;
        end
        if (fault[b] !== 1'b1)
        begin
            n_fail++;
            end_of_test();
        end
        tick(5);
        check(fault, one_hot(b));
        @(posedge i_clk);
        clr <= one_hot(b);
        @(posedge i_clk);
        clr <= 8'h00;
        tick(20);
        check(fault, 8'h00);
        $display("test %s done", name);
    endtask
    // Main sequence
    initial
    begin
        i_resetn = 1'b0;
        ce = 1'b1;
        presc = 16'h0000;
        {trig, stall, raise, lower, lct_lift, lct_end, lct_up} = 7'h00;
        fuse_dly = 16'h0000;
        move_dly = 16'h0000;
        clr = 8'h00;
        tray = '0;
        n_fail = 0;
        check_count = 0;
        void'($urandom(32'h85f5b6d2));
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        tick(2);
        // Fusing motor never reaches speed
        @(posedge i_clk);
        presc <= 16'($urandom_range(0, 1));
        trig <= 1'b1;
        #1;
        expect_fault(exp_cycles(FUSE_START_TK), FLT_FUSER, "fuser start");
        // Motor spins up in time, then jams while driven
        @(posedge i_clk);
        trig <= 1'b0;
        fuse_dly <= 16'($urandom_range(20, 900));
        @(posedge i_clk);
        trig <= 1'b1;
        tick(exp_cycles(FUSE_START_TK) + 20);
        check(fault, 8'h00);
        @(posedge i_clk);
        stall <= 1'b1;
        #1;
        expect_fault(exp_cycles(FUSE_HOLD_TK), FLT_FUSER, "fuser hold");
        @(posedge i_clk);
        trig <= 1'b0;
        presc <= 16'h0000;
        #1;
        // Table stuck going up; a repeated start must restart the count
        strobe(0, 0);
        tick(3000);
        strobe(0, 0);
        expect_fault(exp_cycles(BYPASS_TK), FLT_BYP_UP, "bypass up");
        // Table makes each limit in time
        for (int d = 0; d < 2; d++)
        begin
            @(posedge i_clk);
            move_dly <= 16'($urandom_range(100, 6000));
            strobe(d, 0);
            tick(exp_cycles(BYPASS_TK) + 20);
            check(fault, 8'h00);
        end
        // Table stuck going down
        @(posedge i_clk);
        move_dly <= 16'h0000;
        presc <= 16'($urandom_range(0, 1));
        strobe(1, 0);
        expect_fault(exp_cycles(BYPASS_TK), FLT_BYP_DN, "bypass down");
        @(posedge i_clk);
        presc <= 16'h0000;
        for (int t = 0; t < NUM_TRAYS; t++)
        begin
            // Plate lowers but the sensor never goes high
            strobe(2, t);
            expect_fault(exp_cycles(TRAY_LOWER_TK), tray_bit[t], "tray lower");
            @(posedge i_clk);
            tray[t].upper_limit <= 1'b1;
            // Plate rises again with the sensor stuck made
            strobe(4, t);
            expect_fault(exp_cycles(TRAY_RERISE_TK), tray_bit[t], "tray rerise");
            // Solenoid drops out with the sensor made
            strobe(5, t);
            expect_fault(0, tray_bit[t], "tray solenoid");
        end
        strobe(3, 2);
        expect_fault(exp_cycles(TRAY_RISE_TK), FLT_TRAY4, "tray rise");
        // Large tray lifts, paper end made, upper limit never
        // Enable drops for 500 clocks mid-count: the fault must move out by as much
        @(posedge i_clk);
        lct_lift <= 1'b1;
        @(posedge i_clk);
        lct_end <= 1'b1;
        repeat (1000) @(posedge i_clk);
        ce <= 1'b0;
        repeat (500) @(posedge i_clk);
        ce <= 1'b1;
        #1;
        expect_fault(exp_cycles(LCT_LIFT_TK) - 1000, FLT_LCT, "large tray frozen");
        // Upper limit made in time after a new paper end: no fault
        @(posedge i_clk);
        lct_end <= 1'b0;
        @(posedge i_clk);
        lct_end <= 1'b1;
        repeat (1000) @(posedge i_clk);
        lct_up <= 1'b1;
        tick(exp_cycles(LCT_LIFT_TK));
        check(fault, 8'h00);
        $display("test large tray in time done");
        // A latched flag is dropped by a reset in mid-run
        strobe(5, 0);
        tick(2);
        check(fault, one_hot(FLT_TRAY1));
        @(posedge i_clk);
        i_resetn <= 1'b0;
        lct_lift <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        tick(2);
        check(fault, 8'h00);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule // tb_feed_fuse_fault_monitor
`default_nettype wire
